// file: rtl/fp_assist_grs_rounding.sv
// floating-point assist datapath: grs extension, rounding, fp exceptions
// Notes on behaviour
// - one cell at a time, double shifts two
// - seventeen fp status bits in status register
// - guard, round, sticky readable and writable
// - testexp/replexp clear; right shifts fill extension
// - denorm/normr feed from top or second cell
// - right shifts feed from low shifted cell
// - only norml shifts extension back out
// - left shifts insert zeros, extension untouched
// - sticky stays set until software, testexp or replexp clears
// - nearest-even: guard decides, ties clear bit0
// - toward minus: increment if negative, inexact
// - toward plus: increment if positive, inexact
// - mode field selects; toward zero never changes
// - carry out of bit 31 on round
// - exception sets signal, trap only if enabled
// - exceptions reported together at completion
// - testexp: zero/ones exponent sets carry, signals
// - underflow from norml, addexp, subexp
// - overflow from normr, addexp, subexp
// - normalize if extension nonzero after denorm, normr or norml
// - rounded when round changes top bit0
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/100ps
`include "fp_assist_regs.svh"

module fp_assist_grs_rounding (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire fp_assist_pkg::op_req_t opReq,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  output fp_assist_pkg::op_res_t opRes,
  output fp_assist_pkg::trap_t trapOut,
  output logic carryOut
);

  fp_assist_pkg::fpa_state_t st_q;
  fp_assist_pkg::fpa_state_t st_d;

  // working values of the instruction datapath
  logic [31:0] top;
  logic [31:0] sec;
  logic [31:0] ct;
  logic dbl;
  logic [2:0] grs;
  logic [11:0] ctExp;
  logic [11:0] opExp;
  logic [11:0] expMax;
  logic [11:0] expBias;
  logic [66:0] rVec;
  logic [66:0] rShift;
  logic [66:0] rLostMask;
  logic [5:0] rAmt;
  logic [63:0] lVec;
  logic [32:0] rndSum;
  logic rndInc;
  logic [12:0] expCalc;
  logic [4:0] evt;
  logic [31:0] statusWord;

  // status word as software sees it; upper bits read as zero
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[`FPA_PREC_BIT] = st_q.doublePrecisionSelect;
    statusWord[`FPA_MODE_LSB +: 2] = st_q.roundingSelectField;
    statusWord[`FPA_SIG_LSB +: 5] = st_q.sig;
    statusWord[`FPA_TEN_LSB +: 5] = st_q.trapEn;
    statusWord[`FPA_GRS_LSB +: 3] = st_q.grs;
    statusWord[`FPA_CARRY_BIT] = st_q.carry;
  end

  // next-state logic: register port first, so an instruction's event
  // in the same cycle overrides a software clear of the same flag
  always_comb begin
    st_d = st_q;
    st_d.rdData = 32'h0000_0000;
    st_d.res.valid = 1'b0;
    st_d.trap = '0;
    top = opReq.stackTopCell;
    sec = opReq.stackSecondCell;
    ct = opReq.signExponentCell;
    evt = 5'h00;
    rVec = 67'h0;
    rShift = 67'h0;
    rLostMask = 67'h0;
    rAmt = 6'h00;
    lVec = 64'h0;
    rndSum = 33'h0;
    rndInc = 1'b0;
    expCalc = 13'h0000;

    // register port; unmapped reads return zero
    if (regRd && regAddr == `FPA_STATUS_OFS) begin
      st_d.rdData = statusWord;
    end
    if (regWr && regAddr == `FPA_STATUS_OFS) begin
      st_d.doublePrecisionSelect = regWrData[`FPA_PREC_BIT];
      st_d.roundingSelectField = regWrData[`FPA_MODE_LSB +: 2];
      st_d.sig = regWrData[`FPA_SIG_LSB +: 5];
      st_d.trapEn = regWrData[`FPA_TEN_LSB +: 5];
      st_d.grs = regWrData[`FPA_GRS_LSB +: 3];
      st_d.carry = regWrData[`FPA_CARRY_BIT];
    end

    // precision decides which cell borders the extension
    dbl = st_d.doublePrecisionSelect;
    grs = st_d.grs;
    ctExp = ct[11:0];
    if (dbl) begin
      opExp = {1'b0, top[`FPA_EXP_MSB:`FPA_DBL_EXP_LSB]};
      expMax = `FPA_DBL_EXP_MAX;
      expBias = `FPA_DBL_BIAS;
    end else begin
      opExp = {4'h0, top[`FPA_EXP_MSB:`FPA_SGL_EXP_LSB]};
      expMax = `FPA_SGL_EXP_MAX;
      expBias = `FPA_SGL_BIAS;
    end

    if (opReq.valid) begin
      st_d.res.valid = 1'b1;
      case (opReq.code)
        fp_assist_pkg::OP_TESTEXP: begin
          st_d.grs = 3'h0;
          if (opExp == 12'h000 || opExp == expMax) begin
            st_d.carry = 1'b1;
            evt[`FPA_EXC_EXP] = 1'b1;
          end else begin
            st_d.carry = 1'b0;
          end
        end
        fp_assist_pkg::OP_REPLEXP: begin
          st_d.grs = 3'h0;
          if (dbl) begin
            top[`FPA_EXP_MSB:`FPA_DBL_EXP_LSB] = ctExp[10:0];
          end else begin
            top[`FPA_EXP_MSB:`FPA_SGL_EXP_LSB] = ctExp[7:0];
          end
        end
        fp_assist_pkg::OP_DENORM, fp_assist_pkg::OP_NORMR,
        fp_assist_pkg::OP_SHR, fp_assist_pkg::OP_SHRD: begin
          // one 67-bit frame: {upper, lower, g, r, s}; shr, and denorm/normr
          // in single precision, keep the upper cell empty so zeros enter
          if (opReq.code == fp_assist_pkg::OP_SHRD ||
              (dbl && opReq.code != fp_assist_pkg::OP_SHR)) begin
            rVec = {top, sec, grs};
          end else begin
            rVec = {32'h0000_0000, top, grs};
          end
          if (opReq.code == fp_assist_pkg::OP_SHR ||
              opReq.code == fp_assist_pkg::OP_SHRD) begin
            rAmt = opReq.amt;
          end else begin
            rAmt = 6'h01;
          end
          rShift = rVec >> rAmt;
          rLostMask = ~({67{1'b1}} << rAmt);
          // everything pushed past sticky folds into it
          st_d.grs = {rShift[2:1],
                      rShift[0] | (|(rVec & rLostMask))};
          if (rVec[66:35] != 32'h0000_0000) begin
            top = rShift[66:35];
            sec = rShift[34:3];
          end else if (opReq.code == fp_assist_pkg::OP_SHRD ||
                       (dbl && opReq.code != fp_assist_pkg::OP_SHR)) begin
            top = rShift[66:35];
            sec = rShift[34:3];
          end else begin
            top = rShift[34:3];
          end
          if (opReq.code == fp_assist_pkg::OP_DENORM ||
              opReq.code == fp_assist_pkg::OP_NORMR) begin
            expCalc = {1'b0, ctExp} + 13'h0001;
            ct[11:0] = expCalc[11:0];
            if (opReq.code == fp_assist_pkg::OP_NORMR &&
                expCalc[11:0] >= expMax) begin
              evt[`FPA_EXC_OVF] = 1'b1;
            end
            evt[`FPA_EXC_NRM] = |st_d.grs;
          end
        end
        fp_assist_pkg::OP_NORML: begin
          // guard moves into the cell, sticky keeps its value
          if (dbl) begin
            sec = {sec[30:0], grs[2]};
          end else begin
            top = {top[30:0], grs[2]};
          end
          st_d.grs = {grs[1], grs[0], grs[0]};
          expCalc = {1'b0, ctExp} - 13'h0001;
          ct[11:0] = expCalc[11:0];
          if (expCalc[12] || expCalc[11:0] == 12'h000) begin
            evt[`FPA_EXC_UNF] = 1'b1;
          end
          evt[`FPA_EXC_NRM] = |st_d.grs;
        end
        fp_assist_pkg::OP_SHL: begin
          top = top << opReq.amt;
        end
        fp_assist_pkg::OP_SHLD: begin
          lVec = {top, sec} << opReq.amt;
          top = lVec[63:32];
          sec = lVec[31:0];
        end
        fp_assist_pkg::OP_RND: begin
          case (st_d.roundingSelectField)
            `FPA_RND_NEAR: rndInc = grs[2];
            `FPA_RND_NEG: rndInc = ct[`FPA_SIGN_BIT] & (|grs);
            `FPA_RND_POS: rndInc = ~ct[`FPA_SIGN_BIT] & (|grs);
            default: rndInc = 1'b0;
          endcase
          rndSum = {1'b0, top} + {32'h0000_0000, rndInc};
          if (rndInc) begin
            top = rndSum[31:0];
          end
          // a tie rounds to the even neighbour
          if (st_d.roundingSelectField == `FPA_RND_NEAR && grs == 3'h4) begin
            top[0] = 1'b0;
          end
          st_d.carry = rndInc & rndSum[32];
          if (top[0] != opReq.stackTopCell[0]) begin
            evt[`FPA_EXC_RND] = 1'b1;
          end
        end
        fp_assist_pkg::OP_ADDEXP, fp_assist_pkg::OP_SUBEXP: begin
          // bias is removed once from a sum and added once to a difference, so the result stays biased
          if (opReq.code == fp_assist_pkg::OP_ADDEXP) begin
            expCalc = {1'b0, ctExp} + {1'b0, opExp} - {1'b0, expBias};
          end else begin
            expCalc = {1'b0, ctExp} - {1'b0, opExp} + {1'b0, expBias};
          end
          ct[11:0] = expCalc[11:0];
          if (expCalc[12] || expCalc[11:0] == 12'h000) begin
            evt[`FPA_EXC_UNF] = 1'b1;
          end else if (expCalc[11:0] >= expMax) begin
            evt[`FPA_EXC_OVF] = 1'b1;
          end
        end
        default: begin
          st_d.res.valid = 1'b1;
        end
      endcase
      // all events of one instruction are posted together on completion
      st_d.sig = st_d.sig | evt;
      st_d.trap.mask = evt & st_d.trapEn;
      st_d.trap.valid = |(evt & st_d.trapEn);
      st_d.trap.high = |(evt & st_d.trapEn & 5'h17);
    end
    st_d.res.stackTopCell = top;
    st_d.res.stackSecondCell = sec;
    st_d.res.signExponentCell = ct;
  end

  // single state register for the whole block
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign regRdData = st_q.rdData;
  assign opRes = st_q.res;
  assign trapOut = st_q.trap;
  assign carryOut = st_q.carry;

  // checks on the datapath
  res_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    opReq.valid |=> opRes.valid)
    else $error("result did not follow request");

  zero_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    opReq.valid && opReq.code == fp_assist_pkg::OP_RND && !regWr &&
    st_q.roundingSelectField == `FPA_RND_ZERO
    |=> opRes.stackTopCell == $past(opReq.stackTopCell) && !carryOut)
    else $error("round toward zero changed the cell");

  sticky_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    st_q.grs[0] && !regWr && !(opReq.valid &&
    (opReq.code == fp_assist_pkg::OP_TESTEXP ||
     opReq.code == fp_assist_pkg::OP_REPLEXP)) |=> st_q.grs[0])
    else $error("sticky bit dropped");

  sig_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !regWr |=> (st_q.sig & $past(st_q.sig)) == $past(st_q.sig))
    else $error("signal bit lost without a write");

  trap_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    trapOut.valid |-> (trapOut.mask & ~st_q.trapEn) == 5'h00 &&
    (trapOut.mask & ~st_q.sig) == 5'h00)
    else $error("trap without enable or signal");

  testexp_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    opReq.valid && opReq.code == fp_assist_pkg::OP_TESTEXP &&
    opReq.stackTopCell[`FPA_EXP_MSB:`FPA_DBL_EXP_LSB] == 11'h7FF
    |=> carryOut && st_q.sig[`FPA_EXC_EXP] && st_q.grs == 3'h0)
    else $error("special exponent not flagged");

  shl_grs_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    opReq.valid && !regWr && (opReq.code == fp_assist_pkg::OP_SHL ||
    opReq.code == fp_assist_pkg::OP_SHLD) |=> st_q.grs == $past(st_q.grs))
    else $error("left shift touched extension");

  rounded_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    opRes.valid && $past(opReq.code) == fp_assist_pkg::OP_RND &&
    opRes.stackTopCell[0] != $past(opReq.stackTopCell[0])
    |-> st_q.sig[`FPA_EXC_RND])
    else $error("rounded change not signalled");

  norm_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    opRes.valid && $past(opReq.code) == fp_assist_pkg::OP_NORMR &&
    st_q.grs != 3'h0 |-> st_q.sig[`FPA_EXC_NRM])
    else $error("normalize not signalled");

endmodule

// file: rtl/fp_assist_regs.svh
// register offsets, field positions and limits of the floating-point assist
`ifndef FP_ASSIST_REGS_SVH
`define FP_ASSIST_REGS_SVH

// register map (word offsets on the plain register port)
`define FPA_STATUS_OFS 4'h0
`define FPA_STATUS_RST 32'h0000_0000

// status word field positions
`define FPA_PREC_BIT 0
`define FPA_MODE_LSB 1
`define FPA_SIG_LSB 3
`define FPA_TEN_LSB 8
`define FPA_GRS_LSB 13
`define FPA_CARRY_BIT 16

// exception index within the signal and enable fields
`define FPA_EXC_EXP 0
`define FPA_EXC_UNF 1
`define FPA_EXC_OVF 2
`define FPA_EXC_NRM 3
`define FPA_EXC_RND 4

// rounding-mode encodings
`define FPA_RND_NEAR 2'h0
`define FPA_RND_NEG 2'h1
`define FPA_RND_POS 2'h2
`define FPA_RND_ZERO 2'h3

// exponent layout in the cells
`define FPA_SIGN_BIT 31
`define FPA_EXP_MSB 30
`define FPA_SGL_EXP_LSB 23
`define FPA_DBL_EXP_LSB 20
`define FPA_SGL_EXP_MAX 12'h0FF
`define FPA_DBL_EXP_MAX 12'h7FF
`define FPA_SGL_BIAS 12'h07F
`define FPA_DBL_BIAS 12'h3FF

`endif

// file: rtl/fp_assist_pkg.sv
// types shared by the floating-point assist datapath
package fp_assist_pkg;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_TESTEXP = 4'h1,
    OP_REPLEXP = 4'h2,
    OP_DENORM = 4'h3,
    OP_NORML = 4'h4,
    OP_NORMR = 4'h5,
    OP_SHR = 4'h6,
    OP_SHRD = 4'h7,
    OP_SHL = 4'h8,
    OP_SHLD = 4'h9,
    OP_RND = 4'hA,
    OP_ADDEXP = 4'hB,
    OP_SUBEXP = 4'hC
  } op_t;

  typedef struct packed {
    logic valid;
    op_t code;
    logic [5:0] amt;
    logic [31:0] stackTopCell;
    logic [31:0] stackSecondCell;
    logic [31:0] signExponentCell;
  } op_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] stackTopCell;
    logic [31:0] stackSecondCell;
    logic [31:0] signExponentCell;
  } op_res_t;

  typedef struct packed {
    logic valid;
    logic [4:0] mask;
    logic high;
  } trap_t;

  typedef struct packed {
    logic doublePrecisionSelect;
    logic [1:0] roundingSelectField;
    logic [4:0] sig;
    logic [4:0] trapEn;
    logic [2:0] grs;
    logic carry;
    logic [31:0] rdData;
    op_res_t res;
    trap_t trap;
  } fpa_state_t;

endpackage

// file: verification/fp_seq_model.sv
// sequencer side model: issues one instruction and captures its answer
`timescale 1ns/100ps
module fp_seq_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic go,
  input wire fp_assist_pkg::op_req_t cmd,
  output fp_assist_pkg::op_req_t opReq,
  input wire fp_assist_pkg::op_res_t opRes,
  input wire fp_assist_pkg::trap_t trapOut,
  output fp_assist_pkg::op_res_t lastRes,
  output fp_assist_pkg::trap_t lastTrap,
  output logic gotRes
);
  // idle operands toggle each cycle so stale data never looks valid
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      opReq <= '0;
      gotRes <= 1'b0;
    end else begin
      opReq <= go ? cmd : ~opReq;
      opReq.valid <= go;
      gotRes <= opRes.valid;
      if (opRes.valid) begin
        lastRes <= opRes;
        lastTrap <= trapOut;
      end
    end
  end
endmodule

// file: verification/fp_assist_grs_rounding_tb_top.sv
// self-checking bench of the floating-point assist datapath
`timescale 1ns/100ps
`include "fp_assist_regs.svh"
module fp_assist_grs_rounding_tb_top;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWrData = 32'h00000000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic go = 1'b0;
  fp_assist_pkg::op_req_t cmd = '0;
  fp_assist_pkg::op_req_t opReq;
  fp_assist_pkg::op_res_t opRes;
  fp_assist_pkg::op_res_t lastRes;
  fp_assist_pkg::trap_t trapOut;
  fp_assist_pkg::trap_t lastTrap;
  logic [31:0] regRdData;
  logic [31:0] rd;
  logic [31:0] r;
  logic [31:0] t;
  logic [33:0] e;
  logic carryOut;
  logic gotRes;
  int error_cnt = 0;
  int total_checks = 0;
  int i;

  always #2 sys_clk = ~sys_clk;

  fp_assist_grs_rounding dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .opReq(opReq), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .opRes(opRes), .trapOut(trapOut), .carryOut(carryOut));

  fp_seq_model seq (.sys_clk(sys_clk), .rst_b(rst_b), .go(go),
    .cmd(cmd), .opReq(opReq), .opRes(opRes), .trapOut(trapOut),
    .lastRes(lastRes), .lastTrap(lastTrap), .gotRes(gotRes));

  task automatic chk(input string what, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic regRead(input logic [3:0] a);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(negedge sys_clk);
    rd = regRdData;
  endtask

  task automatic runOp(input fp_assist_pkg::op_t c, input logic [5:0] a,
                       input logic [31:0] top, sec, ct);
    int k;
    @(posedge sys_clk);
    cmd <= '{1'b1, c, a, top, sec, ct};
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    for (k = 0; k < 8 && gotRes !== 1'b1; k++) @(negedge sys_clk);
    if (gotRes !== 1'b1) begin
      error_cnt++;
      report_and_stop;
    end
  endtask

  function automatic logic [31:0] stat(logic [1:0] m, logic [4:0] en,
                                       sg, logic [2:0] g, logic c);
    return {15'h0000, c, g, en, sg, m, 1'b0};
  endfunction

  // returns {rounded, carry, new top}
  function automatic logic [33:0] rndExp(logic [1:0] m, logic s,
                                         logic [2:0] g, logic [31:0] t);
    logic inc;
    logic [32:0] sum;
    inc = (m == `FPA_RND_NEAR) ? g[2] :
          (m == `FPA_RND_NEG) ? (s && g != 3'h0) :
          (m == `FPA_RND_POS) ? (!s && g != 3'h0) : 1'b0;
    sum = {1'b0, t} + {32'h00000000, inc};
    if (m == `FPA_RND_NEAR && g == 3'h4) sum[0] = 1'b0;
    return {sum[0] != t[0], sum[32], sum[31:0]};
  endfunction

  function automatic logic [31:0] lfsr(logic [31:0] x);
    return x[0] ? ((x >> 1) ^ 32'h80200003) : (x >> 1);
  endfunction

  initial begin
    r = 32'h0000002E;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    // reset value, writable fields, reserved bits and a stray address
    regRead(4'h0);
    chk("status rst", rd, `FPA_STATUS_RST);
    regWrite(4'h0, 32'hFFFFFFFF);
    regWrite(4'h5, 32'h00000000);
    regRead(4'h0);
    chk("status rw", rd, 32'h0001FFFF);
    regRead(4'h5);
    chk("unmapped", rd, 32'h00000000);
    // random rounding in all modes; all-ones top carries out whenever rounding increments
    for (i = 0; i < 64; i++) begin
      r = lfsr(r);
      t = r[7] ? 32'hFFFFFFFF : lfsr(r);
      e = rndExp(r[1:0], r[2], r[5:3], t);
      regWrite(4'h0, stat(r[1:0], {r[6], 4'h0}, 5'h00, r[5:3], 1'b0));
      runOp(fp_assist_pkg::OP_RND, 6'h00, t, 32'h0, {r[2], 31'h0});
      chk("rnd top", lastRes.stackTopCell, e[31:0]);
      chk("rnd carry", 32'(carryOut), 32'(e[32]));
      chk("rnd trap", 32'(lastTrap.valid), 32'(r[6] & e[33]));
      regRead(4'h0);
      t = stat(r[1:0], {r[6], 4'h0}, {e[33], 4'h0}, r[5:3], e[32]);
      chk("rnd status", rd, t);
    end
    // right shifts fill the extension, sticky holds, left shifts keep it
    for (i = 0; i < 8; i++) begin
      r = lfsr(r);
      t = lfsr(r);
      regWrite(4'h0, stat(2'h0, 5'h00, 5'h00, 3'h3, 1'b0));
      runOp(fp_assist_pkg::OP_SHR, 6'h01, r, t, 32'h0);
      chk("shr top", lastRes.stackTopCell, r >> 1);
      regRead(4'h0);
      chk("shr grs", 32'(rd[15:13]), {29'h0, r[0], 2'h1});
      runOp(fp_assist_pkg::OP_SHL, 6'h04, r, t, 32'h0);
      chk("shl top", lastRes.stackTopCell, r << 4);
      regRead(4'h0);
      chk("shl grs", 32'(rd[15:13]), {29'h0, r[0], 2'h1});
      runOp(fp_assist_pkg::OP_SHRD, 6'h01, r, t, 32'h0);
      chk("shrd low", lastRes.stackSecondCell, {r[0], t[31:1]});
      regRead(4'h0);
      chk("shrd grs", 32'(rd[15:13]), {29'h0, t[0], r[0], 1'b1});
    end
    // normalize right into overflow, only that trap enabled
    regWrite(4'h0, stat(2'h0, 5'h04, 5'h00, 3'h0, 1'b0));
    runOp(fp_assist_pkg::OP_NORMR, 6'h00, 32'h1, 32'h0, 32'h000000FE);
    chk("normr top", lastRes.stackTopCell, 32'h0);
    t = 32'(lastRes.signExponentCell[11:0]);
    chk("normr exp", t, 32'h000000FF);
    chk("normr trap", 32'(lastTrap), 32'h00000049);
    runOp(fp_assist_pkg::OP_SHL, 6'h01, 32'h0, 32'h0, 32'h0);
    regRead(4'h0);
    chk("normr sig", 32'(rd[7:3]), 32'h0000000C);
    regWrite(4'h0, stat(2'h0, 5'h00, 5'h00, 3'h4, 1'b0));
    regRead(4'h0);
    chk("sig clear", 32'(rd[7:3]), 32'h00000000);
    // normalize left pulls the guard bit back and underflows
    runOp(fp_assist_pkg::OP_NORML, 6'h00, 32'h0, 32'h0, 32'h00000001);
    chk("norml top", lastRes.stackTopCell, 32'h1);
    regRead(4'h0);
    chk("norml sig", 32'(rd[7:3]), 32'h00000002);
    // special exponents set carry and signal; extension always cleared
    for (i = 0; i < 3; i++) begin
      t = (i == 0) ? 32'h7FF00000 : (i == 1) ? 32'h0 : 32'h3F800000;
      regWrite(4'h0, stat(2'h0, 5'h01, 5'h00, 3'h7, 1'b0));
      runOp(fp_assist_pkg::OP_TESTEXP, 6'h00, t, 32'h0, 32'h0);
      regRead(4'h0);
      t = stat(2'h0, 5'h01, {4'h0, i != 2}, 3'h0, i != 2);
      chk("testexp", rd, t);
      chk("testexp trap", 32'(lastTrap.valid), 32'(i != 2));
    end
    regWrite(4'h0, stat(2'h0, 5'h00, 5'h00, 3'h7, 1'b0));
    runOp(fp_assist_pkg::OP_REPLEXP, 6'h00, 32'h0, 32'h0, 32'h0);
    regRead(4'h0);
    chk("replexp grs", 32'(rd[15:13]), 32'h00000000);
    // double precision: exponent arithmetic, denormalize, double left shift
    regWrite(4'h0, 32'h00000001);
    runOp(fp_assist_pkg::OP_ADDEXP, 6'h00, 32'h7FE00000, 32'h0, 32'h400);
    t = 32'(lastRes.signExponentCell[11:0]);
    chk("addexp exp", t, 32'h000007FF);
    runOp(fp_assist_pkg::OP_SUBEXP, 6'h00, 32'h40000000, 32'h0, 32'h1);
    regRead(4'h0);
    chk("exp sig", 32'(rd[7:3]), 32'h00000006);
    runOp(fp_assist_pkg::OP_DENORM, 6'h00, 32'h0, 32'h1, 32'h10);
    chk("denorm sec", lastRes.stackSecondCell, 32'h0);
    regRead(4'h0);
    chk("denorm grs", 32'(rd[15:13]), 32'h00000004);
    chk("denorm sig", 32'(rd[7:3]), 32'h0000000E);
    runOp(fp_assist_pkg::OP_SHLD, 6'h04, 32'h1, 32'hF0000000, 32'h0);
    chk("shld top", lastRes.stackTopCell, 32'h0000001F);
    chk("shld sec", lastRes.stackSecondCell, 32'h0);
    report_and_stop;
  end
endmodule
